// ==== t1tx_map.svh ====
// Constants of the serial frame transmitter: rates, frame geometry and register map.
`ifndef T1TX_MAP_SVH
`define T1TX_MAP_SVH

// Line rate and system clock; one line bit lasts a whole number of pclk cycles.
`define T1TX_LINE_RATE_KHZ  1544
`define T1TX_PCLK_RATE_KHZ  125000
`define T1TX_BIT_CYCLES     (`T1TX_PCLK_RATE_KHZ / `T1TX_LINE_RATE_KHZ)

// Frame geometry.
`define T1TX_BIT_LAST       3'h7
`define T1TX_CHAN_LAST      5'h17
`define T1TX_FRAME_LAST     4'hb
`define T1TX_FRAME_FIRST    4'h0
`define T1TX_TEST_CHAN_LAST 5'h01
`define T1TX_TEST_BIT_LAST  3'h3
`define T1TX_STROBE_LOW_MAX 3'h2
`define T1TX_SIG_FRAME_A    4'h5
`define T1TX_SIG_FRAME_B    4'hb
`define T1TX_ALIGN_PATTERN  12'h3b1

// Sample bit positions (bit 1 of the sample sits at index 0).
`define T1TX_POS_BIT2       1
`define T1TX_POS_BIT7       6
`define T1TX_POS_BIT8       7

// Register map.
`define T1TX_OFS_CTRL       12'h000
`define T1TX_OFS_STATUS     12'h004
`define T1TX_CTRL_RESET     6'h00

`endif

// ==== t1tx_pkg.sv ====
// Types shared by the serial frame transmitter.
package t1tx_pkg;

   typedef struct packed {
      logic alarm;
      logic stuff_bit7_select;
      logic zero_monitor_inhibit;
      logic common_channel_strap;
      logic loop;
      logic test;
   } t1tx_ctrl_t;

   typedef struct packed {
      logic       fbit;
      logic [4:0] chan;
      logic [2:0] bitn;
   } t1tx_slot_t;

   typedef struct packed {
      logic [7:0] data;
      logic       hw_a;
      logic       hw_b;
      logic       alarm;
   } t1tx_sample_t;

   typedef struct packed {
      logic [3:0] frame;
      t1tx_slot_t slot;
   } t1tx_status_t;

endpackage

// ==== t1tx_sync.sv ====
// Two-stage synchroniser for a group of pin inputs.
module t1tx_sync #(
   parameter int unsigned W = 1
) (
   // Clock, reset and freeze
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         ce,
   // Data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta <= '0;
         q    <= '0;
      end else if (ce) begin
         meta <= d;
         q    <= meta;
      end
   end

endmodule

// ==== t1tx_framer.sv ====
// Serial frame transmitter: counters, sample shaping, line outputs and APB registers.
`include "t1tx_map.svh"

module t1tx_framer #(
   parameter int unsigned BIT_CYCLES = `T1TX_BIT_CYCLES
) (
   // Clock, reset and freeze
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Sample source
   input  wire logic [7:0]  sample_in,
   input  wire logic        highway_a_in,
   input  wire logic        highway_b_in,
   input  wire logic        s_bit_in,
   output logic             channel_load_strobe_n,
   // Timing
   input  wire logic        bit_counter_sync_in,
   input  wire logic        frame_counter_sync_in,
   output logic             frame_start_pulse,
   output logic             multiframe_strobe,
   // Line
   output logic             binary_serial_out,
   output logic             unipolar_out_a,
   output logic             unipolar_out_b
);

   localparam logic [7:0] DIV_LAST = 8'(BIT_CYCLES - 1);
   localparam logic [7:0] DIV_HALF = 8'(BIT_CYCLES / 2);
   localparam t1tx_pkg::t1tx_slot_t FRAME_SLOT = '{fbit: 1'b1, chan: 5'h00, bitn: 3'h0};

   t1tx_pkg::t1tx_ctrl_t   ctrl;
   t1tx_pkg::t1tx_slot_t   slot;
   t1tx_pkg::t1tx_slot_t   adv;
   t1tx_pkg::t1tx_slot_t   next_slot;
   t1tx_pkg::t1tx_sample_t held;
   t1tx_pkg::t1tx_status_t status;
   logic [7:0]             div;
   logic [7:0]             cur;
   logic [7:0]             shaped;
   logic [3:0]             frame;
   logic [3:0]             next_frame;
   logic [12:0]            pins_s;
   logic [7:0]             sample_s;
   logic                   hw_a_s;
   logic                   hw_b_s;
   logic                   s_bit_s;
   logic                   bsync_s;
   logic                   fsync_s;
   logic                   tick_rise;
   logic                   tick_fall;
   logic                   frame_inc;
   logic                   load_now;
   logic                   line_bit;
   logic                   out_bit;
   logic                   pol;
   logic                   access;
   logic                   mapped;
   logic                   loop_on;

   // Every sample, highway, signalling and sync pin input crosses two flip-flops before anything looks at it.
   t1tx_sync #(
      .W (13)
   ) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .d       ({sample_in, highway_a_in, highway_b_in, s_bit_in,
                 bit_counter_sync_in, frame_counter_sync_in}),
      .q       (pins_s)
   );

   assign sample_s = pins_s[12:5];
   assign hw_a_s   = pins_s[4];
   assign hw_b_s   = pins_s[3];
   assign s_bit_s  = pins_s[2];
   assign bsync_s  = pins_s[1];
   assign fsync_s  = pins_s[0];
   assign loop_on  = ctrl.loop;

   function automatic logic is_sig_frame(input logic [3:0] f, input logic strap);
      is_sig_frame = !strap && (f == `T1TX_SIG_FRAME_A || f == `T1TX_SIG_FRAME_B);
   endfunction

   function automatic t1tx_pkg::t1tx_slot_t step_slot(input t1tx_pkg::t1tx_slot_t s,
                                                      input logic test);
      step_slot = s;
      if (s.fbit) begin
         step_slot = '{fbit: 1'b0, chan: 5'h00, bitn: 3'h0};
      end else if ((s.bitn == `T1TX_BIT_LAST && s.chan == `T1TX_CHAN_LAST) ||
                   (test && s.chan == `T1TX_TEST_CHAN_LAST &&
                    s.bitn == `T1TX_TEST_BIT_LAST)) begin
         step_slot = FRAME_SLOT;
      end else if (s.bitn == `T1TX_BIT_LAST) begin
         step_slot.bitn = 3'h0;
         step_slot.chan = 5'(s.chan + 5'h01);
      end else begin
         step_slot.bitn = 3'(s.bitn + 3'h1);
      end
   endfunction

   function automatic logic [7:0] shape(input t1tx_pkg::t1tx_sample_t smp,
                                        input logic [3:0] f,
                                        input t1tx_pkg::t1tx_ctrl_t c);
      logic hw;
      shape = smp.data;
      hw    = (f == `T1TX_SIG_FRAME_B) ? smp.hw_b : smp.hw_a;
      if (smp.alarm) begin
         shape[`T1TX_POS_BIT2] = 1'b0;
      end
      if (is_sig_frame(f, c.common_channel_strap)) begin
         shape[`T1TX_POS_BIT8] = hw;
         if (!c.zero_monitor_inhibit && shape[6:0] == 7'h00 && !hw) begin
            shape[`T1TX_POS_BIT7] = 1'b1;
         end
      end else if (!c.zero_monitor_inhibit && shape == 8'h00) begin
         if (c.stuff_bit7_select) begin
            shape[`T1TX_POS_BIT7] = 1'b1;
         end else begin
            shape[`T1TX_POS_BIT8] = 1'b1;
         end
      end
   endfunction

   // Line bit timing: rising line edge at the end of a bit, falling edge half-way.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div <= 8'h00;
      end else if (ce) begin
         div <= (div == DIV_LAST) ? 8'h00 : 8'(div + 8'h01);
      end
   end

   assign tick_rise = ce && (div == DIV_LAST);
   assign tick_fall = ce && (div == DIV_HALF);

   always_comb begin
      adv        = step_slot(slot, ctrl.test);
      next_slot  = slot;
      frame_inc  = 1'b0;
      if (bsync_s) begin
         next_slot = FRAME_SLOT;
      end else if (tick_rise) begin
         next_slot = adv;
         frame_inc = adv.fbit && !slot.fbit;
      end
      next_frame = frame;
      if (fsync_s) begin
         next_frame = `T1TX_FRAME_FIRST;
      end else if (frame_inc) begin
         next_frame = (frame == `T1TX_FRAME_LAST) ? `T1TX_FRAME_FIRST : 4'(frame + 4'h1);
      end
      shaped = shape(held, next_frame, ctrl);
      if (next_slot.fbit) begin
         if (next_frame[0] && ctrl.common_channel_strap) begin
            line_bit = s_bit_s;
         end else begin
            line_bit = 1'(`T1TX_ALIGN_PATTERN >> next_frame);
         end
      end else if (next_slot.bitn == 3'h0) begin
         line_bit = shaped[0];
      end else begin
         line_bit = cur[next_slot.bitn];
      end
      out_bit  = fsync_s | line_bit;
      load_now = tick_rise && ((!next_slot.fbit && next_slot.bitn == `T1TX_BIT_LAST) ||
                               (next_slot.fbit && (bsync_s || slot.bitn != `T1TX_BIT_LAST)));
   end

   // Bit, channel and frame counters.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slot  <= FRAME_SLOT;
         frame <= `T1TX_FRAME_FIRST;
      end else if (ce) begin
         slot  <= next_slot;
         frame <= next_frame;
      end
   end

   // Multiframe strobe follows the frame number's parity, so frame sync sets it at once.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         multiframe_strobe <= 1'b1;
      end else if (ce) begin
         multiframe_strobe <= ~next_frame[0];
      end
   end

   // Next sample, highway bits and alarm are caught together when the strobe falls.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         held <= '0;
      end else if (load_now) begin
         held <= '{data: sample_s, hw_a: hw_a_s, hw_b: hw_b_s, alarm: ctrl.alarm};
      end
   end

   // The shaped sample moves to the output register as its first bit goes out.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur <= 8'h00;
      end else if (tick_rise && !next_slot.fbit && next_slot.bitn == 3'h0) begin
         cur <= shaped;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         channel_load_strobe_n <= 1'b1;
      end else if (tick_rise) begin
         channel_load_strobe_n <= !(next_slot.fbit || next_slot.bitn == `T1TX_BIT_LAST ||
                                    next_slot.bitn <= `T1TX_STROBE_LOW_MAX);
      end
   end

   // Line outputs; the polarity flop remembers which unipolar leg carried the last one.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         binary_serial_out <= 1'b0;
         unipolar_out_a    <= 1'b0;
         unipolar_out_b    <= 1'b0;
         pol               <= 1'b0;
      end else if (tick_rise) begin
         binary_serial_out <= out_bit;
         if (ctrl.loop) begin
            unipolar_out_a <= ~unipolar_out_a;
            unipolar_out_b <= unipolar_out_a;
         end else if (out_bit) begin
            pol            <= ~pol;
            unipolar_out_a <= ~pol;
            unipolar_out_b <= pol;
         end else begin
            unipolar_out_a <= 1'b0;
            unipolar_out_b <= 1'b0;
         end
      end
   end

   // Sampled at mid-bit so it straddles the framing bit and the first data bit.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame_start_pulse <= 1'b0;
      end else if (tick_fall) begin
         frame_start_pulse <= slot.fbit;
      end
   end

   // APB slave: one wait state, answer and data both registered.
   assign access = psel && penable;
   assign mapped = (paddr == `T1TX_OFS_CTRL) || (paddr == `T1TX_OFS_STATUS);
   assign status = '{frame: frame, slot: slot};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else if (ce) begin
         pready  <= access && !pready;
         pslverr <= access && !pready && !mapped;
         prdata  <= 32'h0000_0000;
         if (access && !pready && !pwrite) begin
            if (paddr == `T1TX_OFS_CTRL) begin
               prdata <= 32'(ctrl);
            end else if (paddr == `T1TX_OFS_STATUS) begin
               prdata <= 32'(status);
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= `T1TX_CTRL_RESET;
      end else if (ce && access && pready && pwrite && paddr == `T1TX_OFS_CTRL) begin
         ctrl <= pwdata[$bits(t1tx_pkg::t1tx_ctrl_t)-1:0];
      end
   end

   property p_zero_clears_pair;
      @(posedge pclk) disable iff (!presetn)
      tick_rise && !loop_on && !out_bit |=> !unipolar_out_a && !unipolar_out_b;
   endproperty
   a_zero_clears_pair: assert property (p_zero_clears_pair)
      else $error("unipolar pair not cleared on a zero");

   property p_one_complements;
      @(posedge pclk) disable iff (!presetn)
      tick_rise && !loop_on && out_bit |=> unipolar_out_a != unipolar_out_b && binary_serial_out;
   endproperty
   a_one_complements: assert property (p_one_complements)
      else $error("unipolar pair not complementary on a one");

   // Toggling is only defined once the bit before was a one; after a zero both legs sit low.
   property p_held_fsync;
      @(posedge pclk) disable iff (!presetn)
      tick_rise && fsync_s && !loop_on && binary_serial_out
         |=> binary_serial_out && unipolar_out_a != $past(unipolar_out_a);
   endproperty
   a_held_fsync: assert property (p_held_fsync)
      else $error("held frame sync did not force toggling ones");

   property p_loop_toggle;
      @(posedge pclk) disable iff (!presetn)
      tick_rise && loop_on |=> unipolar_out_a != $past(unipolar_out_a);
   endproperty
   a_loop_toggle: assert property (p_loop_toggle)
      else $error("loop mode did not alternate the unipolar output");

   property p_fsync_frame;
      @(posedge pclk) disable iff (!presetn)
      ce && $rose(fsync_s) |=> frame == `T1TX_FRAME_FIRST ##1 multiframe_strobe;
   endproperty
   a_fsync_frame: assert property (p_fsync_frame)
      else $error("frame sync did not set frame one");

   property p_bsync_hold;
      @(posedge pclk) disable iff (!presetn)
      ce && bsync_s |=> slot.fbit && slot.chan == 5'h00;
   endproperty
   a_bsync_hold: assert property (p_bsync_hold)
      else $error("bit sync did not hold the framing slot");

   // Bit sync and the short test frame also pull the strobe low at the framing slot; after reset it first falls as that slot ends.
   property p_strobe_fall;
      @(posedge pclk) disable iff (!presetn)
      $fell(channel_load_strobe_n) && !$past(ctrl.test) && !$past(slot.fbit) && !$past(bsync_s)
         |-> !slot.fbit && slot.bitn == `T1TX_BIT_LAST;
   endproperty
   a_strobe_fall: assert property (p_strobe_fall)
      else $error("load strobe fell outside bit eight");

   property p_test_wrap;
      @(posedge pclk) disable iff (!presetn)
      tick_rise && ctrl.test && !bsync_s && !slot.fbit && slot.chan == `T1TX_TEST_CHAN_LAST &&
         slot.bitn == `T1TX_TEST_BIT_LAST |=> slot.fbit;
   endproperty
   a_test_wrap: assert property (p_test_wrap)
      else $error("test mode frame did not wrap after thirteen bits");

   property p_sync_pulse_fall;
      @(posedge pclk) disable iff (!presetn)
      !$stable(frame_start_pulse) |-> $past(tick_fall);
   endproperty
   a_sync_pulse_fall: assert property (p_sync_pulse_fall)
      else $error("frame start pulse moved off the mid-bit point");

   property p_sync_pulse_slot;
      @(posedge pclk) disable iff (!presetn)
      $rose(frame_start_pulse) |-> slot.fbit;
   endproperty
   a_sync_pulse_slot: assert property (p_sync_pulse_slot)
      else $error("frame start pulse rose outside the framing bit");

   property p_mf_strobe;
      @(posedge pclk) disable iff (!presetn)
      slot.fbit && $stable(frame) && !frame[0] |-> multiframe_strobe;
   endproperty
   a_mf_strobe: assert property (p_mf_strobe)
      else $error("multiframe strobe low during a frame alignment bit");

endmodule

// ==== t1tx_src_model.sv ====
// Channel bank sample source that feeds the framer one sample per load strobe.
module t1tx_src_model (
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Load strobe from the framer
   input  wire logic       channel_load_strobe_n,
   // Sample, highway and signalling bits
   output logic      [7:0] sample_in,
   output logic            highway_a_in,
   output logic            highway_b_in,
   output logic            s_bit_in
);
   timeunit 1ns;
   timeprecision 1ps;

   int          seed;
   logic        strobe_q;
   logic [31:0] r;

   initial seed = 32'h99a2;

   // New values appear only as the strobe rises, so they stand for four line bits
   // before the next falling edge latches them; a quarter of the samples are all zero.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strobe_q <= 1'b1;
         sample_in <= 8'h00;
         {highway_a_in, highway_b_in, s_bit_in} <= 3'h0;
      end else begin
         strobe_q <= channel_load_strobe_n;
         if (channel_load_strobe_n && !strobe_q) begin
            r = $random(seed);
            sample_in <= (r[1:0] == 2'h0) ? 8'h00 : r[15:8];
            {highway_a_in, highway_b_in, s_bit_in} <= {r[16] & r[2], r[17] & r[3], r[18]};
         end
      end
   end
endmodule

// ==== t1_serial_frame_transmitter_tb.sv ====
// Self-checking bench for the serial frame transmitter.
`include "t1tx_map.svh"

module t1_serial_frame_transmitter_tb;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int unsigned BC    = 8;
   localparam logic [11:0] ALIGN = 12'h3b1;

   logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0]          paddr;
   logic [31:0]          pwdata, prdata;
   logic [7:0]           sample_in, cur;
   logic                 highway_a_in, highway_b_in, s_bit_in, channel_load_strobe_n;
   logic                 bit_counter_sync_in, frame_counter_sync_in, frame_start_pulse;
   logic                 multiframe_strobe, binary_serial_out, unipolar_out_a, unipolar_out_b;
   int                   miscompares, n_checks, seed, cyc, pos, fr, n, run;
   logic [2:0]           ph;
   logic [1:0]           md;
   logic                 al, pol, la, pls, hf, e;
   logic [9:0]           cap;
   t1tx_pkg::t1tx_ctrl_t k;
   event                 smp;

   t1tx_framer #(.BIT_CYCLES(BC)) u_t1tx_framer (
      .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sample_in(sample_in), .highway_a_in(highway_a_in),
      .highway_b_in(highway_b_in), .s_bit_in(s_bit_in),
      .channel_load_strobe_n(channel_load_strobe_n),
      .bit_counter_sync_in(bit_counter_sync_in), .frame_counter_sync_in(frame_counter_sync_in),
      .frame_start_pulse(frame_start_pulse), .multiframe_strobe(multiframe_strobe),
      .binary_serial_out(binary_serial_out), .unipolar_out_a(unipolar_out_a),
      .unipolar_out_b(unipolar_out_b));

   t1tx_src_model u_t1tx_src_model (
      .pclk(pclk), .presetn(presetn), .channel_load_strobe_n(channel_load_strobe_n),
      .sample_in(sample_in), .highway_a_in(highway_a_in), .highway_b_in(highway_b_in),
      .s_bit_in(s_bit_in));

   initial pclk = 1'b0;
   always #4 pclk = ~pclk;

   task automatic print_verdict();
      if (miscompares == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic cmp1(input logic g, input logic x);
      n_checks++;
      if (g !== x) begin
         miscompares++;
         $display("unexpected at %0t: got %h want %h", $time, g, x);
      end
   endtask

   task automatic cmp32(input logic [31:0] g, input logic [31:0] x);
      n_checks++;
      if (g !== x) begin
         miscompares++;
         $display("unexpected at %0t: got %h want %h", $time, g, x);
      end
   endtask

   // The request stands until pready is seen high at a rising edge; the answer is taken there.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   function automatic logic [7:0] shape(input logic [9:0] c, input int f);
      logic [7:0] d;
      logic       h;
      d = c[9:2];
      h = (f == 5) ? c[1] : c[0];
      if (k.alarm)
         d[1] = 1'b0;
      if (!k.common_channel_strap && (f == 5 || f == 11)) begin
         d[7] = h;
         if (!k.zero_monitor_inhibit && d[6:0] == 7'h0 && !h)
            d[6] = 1'b1;
      end else if (!k.zero_monitor_inhibit && d == 8'h0) begin
         if (k.stuff_bit7_select)
            d[6] = 1'b1;
         else
            d[7] = 1'b1;
      end
      return d;
   endfunction

   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         ph <= 3'h0;
      else
         ph <= ph + 3'h1;
   end

   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         miscompares++;
         print_verdict();
      end
   end

   // Line outputs are sampled mid-bit, clear of both the tick and the half-bit edge.
   always @(posedge pclk) begin
      if (presetn && ph == 3'h3) begin
         if (!al && frame_start_pulse) begin
            al = 1'b1;
            pos = 1;
         end else
            pos = (pos + 1) % n;
         if (pos == 0)
            fr = (fr + 1) % 12;
         if (!channel_load_strobe_n && pls) begin
            cap = {sample_in, highway_a_in, highway_b_in};
            if (!md[0] && n == 193)
               cmp1(pos % 8 == 0 && pos != 0, 1'b1);
         end
         if (!channel_load_strobe_n) begin
            run++;
            hf |= (pos == 0);
         end else if (run != 0) begin
            if (!md[0] && n == 193)
               cmp1(run == 4 + hf, 1'b1);
            run = 0;
            hf = 1'b0;
         end
         if (pos == 0)
            e = (k.common_channel_strap && fr[0]) ? s_bit_in : ALIGN[fr];
         else begin
            if ((pos - 1) % 8 == 0)
               cur = shape(cap, fr);
            e = cur[(pos - 1) % 8];
         end
         if (md == 2'h3) begin
            cmp1(binary_serial_out, 1'b1);
            cmp1(unipolar_out_a, ~la);
            cmp1(unipolar_out_b, ~unipolar_out_a);
         end else if (!md[0]) begin
            cmp1(binary_serial_out, e);
            cmp1(frame_start_pulse, pos == 1);
            cmp1(multiframe_strobe, ~fr[0]);
            if (md == 2'h2) begin
               cmp1(unipolar_out_a, ~la);
               cmp1(unipolar_out_b, la);
            end else begin
               pol ^= e;
               cmp1(unipolar_out_a, e & pol);
               cmp1(unipolar_out_b, e & ~pol);
            end
         end
         if (md[0] && binary_serial_out)
            pol = unipolar_out_a;
         la = unipolar_out_a;
         pls = channel_load_strobe_n;
         ->smp;
      end
   end

   task automatic fsync();
      md = 2'h1;
      do @smp; while (pos != 3);
      frame_counter_sync_in <= 1'b1;
      repeat (3) @smp;
      md = 2'h3;
      repeat (6) @smp;
      md = 2'h1;
      repeat (3) @smp;
      frame_counter_sync_in <= 1'b0;
      fr = 0;
      repeat (3) @smp;
      md = 2'h0;
   endtask

   // Settings change mid-frame and checking resumes at the next frame, so no sample
   // is judged against a setting it was not latched under.
   task automatic setc(input t1tx_pkg::t1tx_ctrl_t c, input logic [1:0] m);
      logic [31:0] r;
      logic        err;
      md = 2'h1;
      do @smp; while (pos != 9);
      apb(1'b1, `T1TX_OFS_CTRL, {26'h0, c}, r, err);
      k = c;
      n = c.test ? 13 : 193;
      if (c.test)
         al = 1'b0;
      do @smp; while (pos != 1 || !al);
      md = m;
   endtask

   initial begin
      logic [31:0] r;
      logic [31:0] d;
      logic        err;
      int          i;
      {psel, penable, pwrite, bit_counter_sync_in, frame_counter_sync_in} = 5'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      presetn = 1'b0;
      seed = 32'h99a2;
      {pos, fr, run} = {32'd0, 32'd0, 32'd0};
      n = 193;
      {md, al, pol, la, pls, hf} = 7'h22;
      {cur, cap, k} = 24'h0;
      repeat (6) @(posedge pclk);
      cmp32({pready, channel_load_strobe_n, multiframe_strobe, binary_serial_out,
             unipolar_out_a, unipolar_out_b, frame_start_pulse}, 32'h30);
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `T1TX_OFS_CTRL, 32'h0, r, err);
      cmp32(r, 32'h0);
      d = $random(seed);
      apb(1'b1, `T1TX_OFS_CTRL, d, r, err);
      apb(1'b0, `T1TX_OFS_CTRL, 32'h0, r, err);
      cmp32(r, d & 32'h3f);
      apb(1'b1, `T1TX_OFS_CTRL, 32'h0, r, err);
      apb(1'b1, 12'h008, d, r, err);
      cmp1(err, 1'b1);
      apb(1'b0, 12'h008, 32'h0, r, err);
      cmp32({r[30:0], err}, 32'h1);
      apb(1'b0, `T1TX_OFS_CTRL, 32'h0, r, err);
      cmp32(r, 32'h0);
      cmp1(err, 1'b0);
      apb(1'b0, `T1TX_OFS_STATUS, 32'h0, r, err);
      cmp32(r & 32'hffffe000, 32'h0);
      al = 1'b0;
      do @smp; while (!al);
      fsync();
      repeat (12 * 193) @smp;
      setc(6'h02, 2'h2);
      repeat (24) @smp;
      setc(6'h34, 2'h0);
      repeat (6 * 193) @smp;
      setc(6'h08, 2'h0);
      repeat (6 * 193) @smp;
      setc(6'h01, 2'h1);
      fsync();
      repeat (52) @smp;
      md = 2'h1;
      bit_counter_sync_in <= 1'b1;
      repeat (8) @smp;
      bit_counter_sync_in <= 1'b0;
      al = 1'b0;
      i = 0;
      // The held pulse is still up at the first data bit's sample and drops at that bit's mid-point.
      do begin
         @smp;
         i++;
      end while (frame_start_pulse && i < 8);
      cmp1(i == 2, 1'b1);
      fsync();
      repeat (52) @smp;
      print_verdict();
   end
endmodule
